// ---- rtl/pattern_pkg.sv ----
// shared constants for the lvds test pattern selector
package pattern_pkg;
    localparam int          SAMPLE_W       = 12;
    localparam int          NUM_BUS        = 4;
    localparam int          PAT_LEN        = 8;
    localparam int          IDX_W          = 3;
    // register offsets
    localparam logic [3:0]  ADDR_LINK_CTRL = 4'h0;
    localparam logic [3:0]  ADDR_PAT_CHOICE = 4'h1;
    localparam logic [3:0]  ADDR_USER_PATTERN_CONTROL_REG = 4'h2;
    localparam logic [3:0]  ADDR_STATUS    = 4'h3;
    localparam logic [3:0]  ADDR_UPAT_BASE = 4'h8;
    // link control fields
    localparam int          LC_SYNC_SRC    = 0;
    localparam int          LC_SYNC_SOFT   = 1;
    localparam int          LC_SCRAMBLE    = 2;
    localparam logic [2:0]  LC_RESET       = 3'h0;
    // pattern choice fields
    localparam int          PC_ACT         = 0;
    localparam int          PC_ALIGN_LO    = 4;
    localparam logic [5:0]  PC_RESET       = 6'h00;
    // user pattern control fields
    localparam int          UC_INV_LO      = 0;
    localparam int          UC_LANE        = 4;
    localparam logic [4:0]  UC_RESET       = 5'h00;
    localparam logic [11:0] UPAT_RESET     = 12'h000;
    localparam int          INV_BIT_BASE   = 8;
    // values
    localparam logic [11:0] MID_CODE       = 12'h000;
    localparam logic [7:0]  LANE_SEQ       = 8'hE2;
    // alignment pattern encodings
    typedef enum logic [1:0] {
        ALIGN_USER   = 2'h0,
        ALIGN_LSB    = 2'h1,
        ALIGN_STROBE = 2'h2
    } align_t;
endpackage : pattern_pkg

// ---- rtl/edge_sync.sv ----
// two-flop synchroniser with falling edge detect
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // signal
    input  wire logic din,
    output logic      level,
    output logic      fall
);
    logic meta_q, sync_q, prev_q;
    logic meta_d, sync_d, prev_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level = sync_q;
    assign fall  = prev_q & ~sync_q;
endmodule : edge_sync
`default_nettype wire

// ---- rtl/upat_mem.sv ----
// eight-word user pattern store with registered read
`timescale 1ns/1ps
`default_nettype none
module upat_mem
    import pattern_pkg::*;
#(
    parameter int W     = SAMPLE_W,
    parameter int DEPTH = PAT_LEN,
    parameter int AW    = IDX_W
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // read ports
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata,
    input  wire logic [AW-1:0] baddr,
    output logic      [W-1:0]  bdata
);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [W-1:0] rdata_d, bdata_d;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = (we && waddr == AW'(i)) ? wdata : mem_q[i];
        end
        rdata_d = mem_q[raddr];
        bdata_d = mem_q[baddr];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= UPAT_RESET;
            end
            rdata <= '0;
            bdata <= '0;
        end else if (ce) begin
            mem_q <= mem_d;
            rdata <= rdata_d;
            bdata <= bdata_d;
        end
    end
endmodule : upat_mem
`default_nettype wire

// ---- rtl/lvds_test_pattern_select.sv ----
// output pattern selector for four lvds data buses
//
// How it works
// [RQ1] hold active and alignment pattern, choose by source
// [RQ2] toggle pin selects pattern out of reset
// [RQ3] pattern switches only on strobe falling edge
// [RQ4] active field: samples or user pattern
// [RQ5] strobe on lsb, or user pattern
// [RQ6] strobe replaces every active lane
// [RQ7] eight pattern words restart each frame
// [RQ8] short frames truncate, long frames repeat
// [RQ9] per-bus inversion of bits eight to eleven
// [RQ10] inversion touches only its own bus
// [RQ11] lane sequence overrides user pattern
// [RQ12] lane sequence 000 fff 000 000 000 fff fff fff
// [RQ13] lane sequence uses same frame handling
// [RQ14] power down disables all data drivers
// [RQ15] receiver relinks and flushes after power down
// [RQ16] calibration outputs mid-code instead of samples
// [RQ17] scrambling applied to output when enabled
// [RQ18] three-bit index cleared on frame edge
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lvds_test_pattern_select
    import pattern_pkg::*;
(
    // clock, reset, enable
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         ce,
    // register port
    input  wire logic [3:0]                   reg_addr,
    input  wire logic [pattern_pkg::SAMPLE_W-1:0] reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic [pattern_pkg::SAMPLE_W-1:0]  reg_rdata,
    // pins
    input  wire logic                         pattern_toggle_pin,
    input  wire logic                         power_down_pin,
    // converter data path
    input  wire logic                         sample_valid,
    input  wire logic                         frame_strobe,
    input  wire logic                         fg_cal_active,
    input  wire logic [pattern_pkg::NUM_BUS*pattern_pkg::SAMPLE_W-1:0] adc_data,
    // lvds outputs
    output logic [pattern_pkg::NUM_BUS*pattern_pkg::SAMPLE_W-1:0] lane_data,
    output logic [pattern_pkg::NUM_BUS-1:0]   lane_strobe,
    output logic                              lane_oe,
    output logic                              align_active
);
    import pattern_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic toggle_s, pd_s, strobe_s, strobe_fall;

    edge_sync u_toggle (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .din   (pattern_toggle_pin),
        .level (toggle_s),
        .fall  ()
    );

    edge_sync u_pd (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .din   (power_down_pin),
        .level (pd_s),
        .fall  ()
    );

    // strobe is on this clock, but the edge detector gives fall
    // aligned with the delayed level; data is delayed to match
    edge_sync u_strobe (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .din   (frame_strobe),
        .level (strobe_s),
        .fall  (strobe_fall)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2:0]  link_control_q, link_control_d;
    logic [5:0]  pattern_choice_q, pattern_choice_d;
    logic [4:0]  user_pattern_control_q, user_pattern_control_d;
    logic [SAMPLE_W-1:0] rdata_d;
    logic        upat_we;
    logic [SAMPLE_W-1:0] mem_rdata;
    logic [SAMPLE_W-1:0] user_word;
    logic [IDX_W-1:0]    idx_q, idx_d;
    logic                sel_align_q, sel_align_d;
    logic                rd_mem_q, rd_mem_d;

    assign upat_we = reg_wr && reg_addr[3];

    upat_mem u_mem (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .we    (upat_we),
        .waddr (reg_addr[IDX_W-1:0]),
        .wdata (reg_wdata),
        .raddr (reg_addr[IDX_W-1:0]),
        .rdata (mem_rdata),
        .baddr (idx_d),
        .bdata (user_word)
    );

    always_comb begin
        link_control_d         = link_control_q;
        pattern_choice_d       = pattern_choice_q;
        user_pattern_control_d = user_pattern_control_q;
        rdata_d                = '0;
        rd_mem_d               = reg_rd && reg_addr[3];
        if (reg_wr) begin
            case (reg_addr)
                ADDR_LINK_CTRL:  link_control_d   = reg_wdata[2:0];
                ADDR_PAT_CHOICE: pattern_choice_d = reg_wdata[5:0];
                ADDR_USER_PATTERN_CONTROL_REG:  user_pattern_control_d = reg_wdata[4:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_LINK_CTRL:  rdata_d = {9'h000, link_control_q};
                ADDR_PAT_CHOICE: rdata_d = {6'h00, pattern_choice_q};
                ADDR_USER_PATTERN_CONTROL_REG:  rdata_d = {7'h00, user_pattern_control_q};
                ADDR_STATUS:     rdata_d = {6'h00, pd_s, toggle_s,
                                            sel_align_q, idx_q};
                default:         rdata_d = '0;
            endcase
        end
    end

    logic [SAMPLE_W-1:0] rdata_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link_control_q         <= LC_RESET;
            pattern_choice_q       <= PC_RESET;
            user_pattern_control_q <= UC_RESET;
            rdata_q                <= '0;
            rd_mem_q               <= 1'b0;
        end else if (ce) begin
            link_control_q         <= link_control_d;
            pattern_choice_q       <= pattern_choice_d;
            user_pattern_control_q <= user_pattern_control_d;
            rdata_q                <= rdata_d;
            rd_mem_q               <= rd_mem_d;
        end
    end

    assign reg_rdata = rd_mem_q ? mem_rdata : rdata_q;

    // ------------------------------------------------------------
    // frame tracking and pattern switching
    // ------------------------------------------------------------
    logic req_align;
    // register source bit picks pin or software request
    assign req_align = link_control_q[LC_SYNC_SRC] ?
                       link_control_q[LC_SYNC_SOFT] : toggle_s; // [RQ1] [RQ2]

    always_comb begin
        idx_d       = idx_q;
        sel_align_d = sel_align_q;
        if (strobe_fall) begin
            idx_d       = '0; // [RQ18] [RQ7]
            sel_align_d = req_align; // [RQ3]
        end else if (sample_valid) begin
            idx_d = idx_q + 1'b1; // [RQ8] [RQ13]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q       <= '0;
            sel_align_q <= 1'b0;
        end else if (ce) begin
            idx_q       <= idx_d;
            sel_align_q <= sel_align_d;
        end
    end

    // ------------------------------------------------------------
    // data path: delay samples to line up with user word
    // ------------------------------------------------------------
    logic [NUM_BUS*SAMPLE_W-1:0] adc_q1, adc_q2, adc_q3;
    logic                        strb_q;
    logic [NUM_BUS*SAMPLE_W-1:0] lane_d;
    logic [NUM_BUS-1:0]          strobe_d;
    logic                        oe_d;
    logic [SAMPLE_W-1:0]         base_word;
    align_t                      align_sel;
    logic                        use_user;

    assign align_sel = align_t'(pattern_choice_q[PC_ALIGN_LO +: 2]);
    // lane sequence wins over programmed words
    assign base_word = user_pattern_control_q[UC_LANE] ?
                       {SAMPLE_W{LANE_SEQ[idx_q]}} : user_word; // [RQ11] [RQ12]

    always_comb begin
        lane_d   = '0;
        strobe_d = {NUM_BUS{strb_q}};
        oe_d     = ~pd_s;
        use_user = sel_align_q ? (align_sel == ALIGN_USER)
                               : pattern_choice_q[PC_ACT]; // [RQ4] [RQ5]
        for (int b = 0; b < NUM_BUS; b++) begin
            logic [SAMPLE_W-1:0] w;
            logic [SAMPLE_W-1:0] s;
            w = '0;
            s = fg_cal_active ? MID_CODE : adc_q3[b*SAMPLE_W +: SAMPLE_W]; // [RQ16]
            if (use_user) begin
                w = base_word;
                // each bus flips only its own bit
                w[INV_BIT_BASE+b] = base_word[INV_BIT_BASE+b] ^
                    user_pattern_control_q[UC_INV_LO+b]; // [RQ9] [RQ10]
            end else if (sel_align_q && align_sel == ALIGN_STROBE) begin
                w = {SAMPLE_W{strb_q}}; // [RQ6]
            end else if (sel_align_q && align_sel == ALIGN_LSB) begin
                w = {s[SAMPLE_W-1:1], strb_q}; // [RQ5]
            end else begin
                w = s;
            end
            if (link_control_q[LC_SCRAMBLE]) begin
                // memoryless xor scrambler, 12-bit layout
                strobe_d[b] = strb_q ^ w[1] ^ w[0]; // [RQ17]
                w = {w[11:2] ^ {10{w[1] ^ w[0]}}, w[1], w[0] ^ w[1]}; // [RQ17]
            end
            lane_d[b*SAMPLE_W +: SAMPLE_W] = w;
        end
        if (pd_s) begin
            lane_d   = '0; // [RQ14]
            strobe_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adc_q1      <= '0;
            adc_q2      <= '0;
            adc_q3      <= '0;
            strb_q      <= 1'b0;
            lane_data   <= '0;
            lane_strobe <= '0;
            lane_oe     <= 1'b0;
        end else if (ce) begin
            adc_q1      <= adc_data;
            adc_q2      <= adc_q1;
            adc_q3      <= adc_q2;
            strb_q      <= strobe_s;
            lane_data   <= lane_d;
            lane_strobe <= strobe_d;
            lane_oe     <= oe_d; // [RQ14]
        end
    end

    // receiver must discard output after lane_oe returns [RQ15]
    assign align_active = sel_align_q;
endmodule : lvds_test_pattern_select
`default_nettype wire

// ---- tb/lvds_rx_model.sv ----
// receiving end model that captures the four buses
`timescale 1ns/1ps
`default_nettype none
module lvds_rx_model #(
    parameter int FLUSH = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // lvds side
    input  wire logic [47:0] lane_data,
    input  wire logic        lane_oe,
    // user side
    output logic      [47:0] rx_word,
    output logic             rx_ok
);
    int unsigned wait_cnt;
    // words are dropped until the stale pipeline drains after drivers return
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= FLUSH;
            rx_ok    <= 1'b0;
        end else if (!lane_oe) begin
            wait_cnt <= FLUSH;
            rx_ok    <= 1'b0;
        end else if (wait_cnt != 0) begin
            wait_cnt <= wait_cnt - 1;
        end else begin
            rx_ok <= 1'b1;
        end
        rx_word <= lane_data;
    end
endmodule : lvds_rx_model
`default_nettype wire

// ---- tb/lvds_test_pattern_select_monitor.sv ----
// assertion checker for the lvds test pattern selector
`timescale 1ns/1ps
`default_nettype none
module lvds_test_pattern_select_monitor
    import pattern_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        ce,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [11:0] reg_wdata,
    input wire logic        reg_wr,
    // pins and data
    input wire logic        power_down_pin,
    input wire logic        frame_strobe,
    input wire logic        fg_cal_active,
    input wire logic [47:0] adc_data,
    input wire logic [47:0] lane_data,
    input wire logic        lane_oe,
    input wire logic        align_active
);
    logic [5:0] pc_q, pc_d;
    logic       scr_q, scr_d, fs_q, fs_d;
    logic [3:0] quiet_q, quiet_d, fall_q, fall_d;
    logic       plain;
    // shadow of the mode fields; quiet counts cycles since the last register write or power down
    always_comb begin
        pc_d    = pc_q;
        scr_d   = scr_q;
        fs_d    = fs_q;
        quiet_d = quiet_q + {3'h0, quiet_q != 4'hF};
        fall_d  = fall_q + {3'h0, fall_q != 4'hF};
        if (ce) begin
            if (reg_wr && reg_addr == ADDR_PAT_CHOICE) pc_d = reg_wdata[5:0];
            if (reg_wr && reg_addr == ADDR_LINK_CTRL) scr_d = reg_wdata[2];
            if (reg_wr || power_down_pin) quiet_d = 4'h0;
            if (fs_q && !frame_strobe) fall_d = 4'h0;
            fs_d = frame_strobe;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q    <= 6'h00;
            scr_q   <= 1'b0;
            fs_q    <= 1'b0;
            quiet_q <= 4'h0;
            fall_q  <= 4'hF;
        end else begin
            pc_q    <= pc_d;
            scr_q   <= scr_d;
            fs_q    <= fs_d;
            quiet_q <= quiet_d;
            fall_q  <= fall_d;
        end
    end
    assign plain = quiet_q == 4'hF && !scr_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_act; (!align_active && !fg_cal_active) [*6]; endsequence
    sequence s_aln; (align_active && !fg_cal_active) [*6]; endsequence
    sequence s_cal; (!align_active && fg_cal_active) [*6]; endsequence
    sequence s_steady;
        $past(adc_data, 3) == $past(adc_data, 4) &&
        $past(adc_data, 4) == $past(adc_data, 5);
    endsequence
    property p_pd_oe; power_down_pin [*5] |-> !lane_oe; endproperty
    property p_pd_data; power_down_pin [*5] |-> lane_data == 48'h0; endproperty
    property p_run_oe; !power_down_pin [*5] |-> lane_oe; endproperty
    property p_frame;
        // two synchroniser flops and the selection register: always 2
        align_active != $past(align_active) |-> fall_q == 4'h2;
    endproperty
    property p_adc;
        s_act ##0 s_steady ##0 (plain && !pc_q[0])
            |-> lane_data == $past(adc_data, 4);
    endproperty
    property p_cal;
        s_cal ##0 (quiet_q == 4'hF && !pc_q[0]) |-> lane_data == 48'h0;
    endproperty
    property p_all;
        s_aln ##0 (plain && pc_q[5:4] == 2'h2)
            |-> lane_data == 48'h0 || lane_data == {48{1'b1}};
    endproperty
    property p_lsb;
        s_aln ##0 s_steady ##0 (plain && pc_q[5:4] == 2'h1)
            |-> ((lane_data ^ $past(adc_data, 4)) & {4{12'hFFE}}) == 48'h0;
    endproperty
    a_pd_oe: assert property (p_pd_oe)
        else $error("drivers on in power down");
    a_pd_data: assert property (p_pd_data)
        else $error("lane data not zero in power down");
    a_run_oe: assert property (p_run_oe)
        else $error("drivers off while running");
    a_frame: assert property (p_frame)
        else $error("pattern switched away from a frame edge");
    a_adc: assert property (p_adc)
        else $error("samples not passed through");
    a_cal: assert property (p_cal)
        else $error("no mid code during calibration");
    a_all: assert property (p_all)
        else $error("lanes do not carry the strobe");
    a_lsb: assert property (p_lsb)
        else $error("upper bits lost in lsb strobe mode");
endmodule : lvds_test_pattern_select_monitor
bind lvds_test_pattern_select lvds_test_pattern_select_monitor u_mon (
    .clk, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr, .power_down_pin,
    .frame_strobe, .fg_cal_active, .adc_data, .lane_data, .lane_oe,
    .align_active
);
`default_nettype wire

// ---- tb/lvds_test_pattern_select_tb_top.sv ----
// self-checking bench for the lvds test pattern selector
`timescale 1ns/1ps
`default_nettype none
module lvds_test_pattern_select_tb_top;
    import pattern_pkg::*;
    typedef struct packed {
        logic [11:0] lc, pc, uc;
        logic        cal;
        logic [47:0] exp;
    } row_t;
    localparam logic [11:0] UW = 12'h5A3;
    logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sample_valid = 1;
    logic pattern_toggle_pin = 0, power_down_pin = 0, fg_cal_active = 0;
    logic frame_strobe = 0, lane_oe, align_active, rx_ok;
    logic [3:0]  reg_addr = 4'h0, lane_strobe;
    logic [11:0] reg_wdata = 12'h000, reg_rdata;
    logic [47:0] adc_data = 48'h123456789ABC, lane_data, rx_word;
    logic [11:0] useq [8];
    logic [11:0] lseq [8] = '{12'h000, 12'hFFF, 12'h000, 12'h000,
                              12'h000, 12'hFFF, 12'hFFF, 12'hFFF};
    int fails = 0, tests_run = 0, cyc = 0, n, flen = 8, fcnt = 0;
    row_t rows [8] = '{
        '{0, 0, 0, 0, 48'h123456789ABC},
        '{0, 1, 0, 0, {4{UW}}},
        '{0, 1, 1, 0, {UW, UW, UW, 12'h4A3}},
        '{0, 1, 2, 0, {UW, UW, 12'h7A3, UW}},
        '{0, 1, 4, 0, {UW, 12'h1A3, UW, UW}},
        '{0, 1, 8, 0, {12'hDA3, UW, UW, UW}},
        '{0, 0, 0, 1, 48'h0},
        '{4, 1, 0, 0, {4{12'h5A2}}}};
    lvds_test_pattern_select u_lvds_test_pattern_select (
        .clk, .rst_b, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pattern_toggle_pin, .power_down_pin, .sample_valid,
        .frame_strobe, .fg_cal_active, .adc_data, .lane_data,
        .lane_strobe, .lane_oe, .align_active);
    lvds_rx_model u_lvds_rx_model (
        .clk, .rst_b, .lane_data, .lane_oe, .rx_word, .rx_ok);
    always #5 clk = ~clk;
    // frame strobe is high for the first half of every frame
    always @(posedge clk) begin
        fcnt <= (fcnt + 1 >= flen) ? 0 : fcnt + 1;
        frame_strobe <= fcnt < flen / 2;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [11:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk({36'h0, reg_rdata}, {36'h0, e});
        @(posedge clk);
    endtask : rd
    // a periodic pattern may start anywhere in the capture, so try all phases
    task automatic frame_chk(input int p, input logic [11:0] s [8]);
        logic [11:0] got [22];
        int hit;
        hit = 0;
        repeat (30) @(posedge clk);
        for (int k = 0; k < 2 * p; k++) begin
            @(negedge clk);
            got[k] = rx_word[11:0];
        end
        for (int r = 0; r < p; r++) begin
            int ok = 1;
            // one sample past the frame end must restart the pattern
            for (int k = 0; k <= p; k++)
                ok &= int'(got[k + r] === s[(k % p) % 8]);
            hit |= ok;
        end
        chk(48'(hit), 48'h1);
    endtask : frame_chk
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_LINK_CTRL, 12'h000);
        rd(ADDR_PAT_CHOICE, 12'h000);
        wr(4'h4, 12'hFFF);
        rd(4'h4, 12'h000);
        for (int k = 0; k < 8; k++) wr(ADDR_UPAT_BASE + 4'(k), UW);
        foreach (rows[i]) begin
            wr(ADDR_LINK_CTRL, rows[i].lc);
            wr(ADDR_PAT_CHOICE, rows[i].pc);
            wr(ADDR_USER_PATTERN_CONTROL_REG, rows[i].uc);
            fg_cal_active <= rows[i].cal;
            repeat (16) @(posedge clk);
            // look between edges, away from the capture register's update
            @(negedge clk);
            chk(rx_word, rows[i].exp);
            @(posedge clk);
        end
        fg_cal_active <= 1'b0;
        note("rows");
        for (int k = 0; k < 8; k++) begin
            useq[k] = 12'h0C0 + 12'(k);
            wr(ADDR_UPAT_BASE + 4'(k), useq[k]);
        end
        rd(ADDR_UPAT_BASE + 4'h2, 12'h0C2);
        wr(ADDR_LINK_CTRL, 12'h000);
        flen <= 11;
        frame_chk(11, useq);
        flen <= 5;
        frame_chk(5, useq);
        wr(ADDR_USER_PATTERN_CONTROL_REG, 12'h010);
        frame_chk(5, lseq);
        flen <= 8;
        frame_chk(8, lseq);
        note("frames");
        wr(ADDR_PAT_CHOICE, 12'h020);
        pattern_toggle_pin <= 1'b1;
        repeat (30) @(posedge clk);
        chk(48'(align_active), 48'h1);
        n = 0;
        repeat (8) begin
            @(negedge clk);
            n += int'(rx_word[11:0] == 12'hFFF);
            chk(48'(lane_strobe), 48'({4{lane_data[0]}}));
        end
        chk(48'(n), 48'h4);
        wr(ADDR_PAT_CHOICE, 12'h010);
        repeat (30) @(posedge clk);
        n = 0;
        repeat (8) begin
            @(negedge clk);
            n += int'(rx_word[0]);
            chk(48'(rx_word[11:1]), 48'h55E);
        end
        chk(48'(n), 48'h4);
        wr(ADDR_LINK_CTRL, 12'h001);
        repeat (30) @(posedge clk);
        chk(48'(align_active), 48'h0);
        pattern_toggle_pin <= 1'b0;
        wr(ADDR_LINK_CTRL, 12'h003);
        repeat (30) @(posedge clk);
        chk(48'(align_active), 48'h1);
        wr(ADDR_LINK_CTRL, 12'h000);
        note("align");
        power_down_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk(lane_data, 48'h0);
        chk(48'(lane_oe), 48'h0);
        power_down_pin <= 1'b0;
        repeat (4) @(posedge clk);
        chk(48'(rx_ok), 48'h0);
        repeat (20) @(posedge clk);
        chk(48'(rx_ok), 48'h1);
        note("power down");
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_PAT_CHOICE, 12'h000);
        note("reset");
        results();
    end
endmodule : lvds_test_pattern_select_tb_top
`default_nettype wire
